/* hw/pcl_pkg.sv */
// Package: constants and types of the parallel configuration loader
package pcl_pkg;

  // System clock and power-on-reset delay
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned POR_TIME_NS   = 100_000;
  localparam int unsigned POR_CYCLES    =
    (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POR_CW        = 12;

  // Data path
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned WORDS_DFLT    = 4096;
  localparam int unsigned OPT_INIT_BIT  = 0;
  localparam int unsigned INIT_EDGES    = 2;
  localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;

  // Bus width strap encoding
  typedef enum logic [1:0] {
    PCL_W8  = 2'h0,
    PCL_W16 = 2'h1,
    PCL_W32 = 2'h2
  } pcl_width_t;

  // Sequencer states, Gray along power-on, load, loaded, user
  typedef enum logic [2:0] {
    PCL_POR    = 3'h0,
    PCL_CFG    = 3'h1,
    PCL_LOADED = 3'h3,
    PCL_USER   = 3'h2,
    PCL_HOLD   = 3'h6,
    PCL_ERR    = 3'h7
  } pcl_state_t;

  // One configuration word on its way to the core
  typedef struct packed {
    logic              last;
    logic [DATA_W-1:0] data;
  } pcl_word_t;

endpackage : pcl_pkg

/* hw/pcl_sync.sv */
// Two-stage level synchroniser with asynchronous clear
`timescale 1ns/1ps
`default_nettype none
module pcl_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Destination clock and clear
  input  wire logic             clk,
  input  wire logic             clr,
  // Level in, synchronised level out
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge clr) begin
    if (clr) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : pcl_sync
`default_nettype wire

/* hw/pcl_fifo.sv */
// Dual-clock FIFO with Gray-coded pointers
`timescale 1ns/1ps
`default_nettype none
module pcl_fifo #(
  parameter int unsigned WIDTH = 33,
  parameter int unsigned DEPTH = 16
) (
  // Write side
  input  wire logic             wr_clk,
  input  wire logic             wr_clr,
  input  wire logic             wr_valid,
  output var  logic             wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic             rd_clk,
  input  wire logic             rd_clr,
  output var  logic             rd_valid,
  input  wire logic             rd_ready,
  output var  logic [WIDTH-1:0] rd_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wbin_r;
  logic [AW:0]      rbin_r;
  logic [AW:0]      wgray_r;
  logic [AW:0]      rgray_r;
  logic [AW:0]      wgray_s;
  logic [AW:0]      rgray_s;
  logic [AW:0]      wbin_nxt;
  logic [AW:0]      rbin_nxt;
  wire              wr_fire;
  wire              rd_fire;

  // Pointer arithmetic and flags
  assign wbin_nxt = wbin_r + (AW+1)'(1);
  assign rbin_nxt = rbin_r + (AW+1)'(1);
  assign wr_ready = wgray_r != {~rgray_s[AW:AW-1], rgray_s[AW-2:0]};
  assign rd_valid = rgray_r != wgray_s;
  assign wr_fire  = wr_valid & wr_ready;
  assign rd_fire  = rd_valid & rd_ready;
  assign rd_data  = mem_r[rbin_r[AW-1:0]];

  // Storage needs no reset; flags guard every read
  always_ff @(posedge wr_clk) begin
    if (wr_fire) begin
      mem_r[wbin_r[AW-1:0]] <= wr_data;
    end
  end

  // Write pointer
  always_ff @(posedge wr_clk or posedge wr_clr) begin
    if (wr_clr) begin
      wbin_r  <= '0;
      wgray_r <= '0;
    end else if (wr_fire) begin
      wbin_r  <= wbin_nxt;
      wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
    end
  end

  // Read pointer
  always_ff @(posedge rd_clk or posedge rd_clr) begin
    if (rd_clr) begin
      rbin_r  <= '0;
      rgray_r <= '0;
    end else if (rd_fire) begin
      rbin_r  <= rbin_nxt;
      rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
    end
  end

  // Pointer crossings
  pcl_sync #(.WIDTH(AW+1)) u_wsync (
    .clk (rd_clk),
    .clr (rd_clr),
    .d   (wgray_r),
    .q   (wgray_s)
  );
  pcl_sync #(.WIDTH(AW+1)) u_rsync (
    .clk (wr_clk),
    .clr (wr_clr),
    .d   (rgray_r),
    .q   (rgray_s)
  );

endmodule : pcl_fifo
`default_nettype wire

/* hw/pcl_loader.sv */
// Passive parallel configuration port, device side
//
// Summary of operation
// - request low in user mode restarts configuration
// - user mode leaves status, done, init-done high
// - status held low for power-on delay
// - done low from power-up through transfer
// - done released only after all words arrive
// - narrow modes use the low data bits
// - data pins freed to user after configuration
// - configuration clock ignored once configured
// - init-done pulled low until initialization ends
// - one data word per configuration clock
`timescale 1ns/1ps
`default_nettype none
module pcl_loader
  import pcl_pkg::*;
#(
  parameter int unsigned BITSTREAM_WORDS = pcl_pkg::WORDS_DFLT
) (
  // System clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Configuration link clock from the host
  input  wire logic                      config_clock,
  // Host control and data pins
  input  wire logic                      reconfig_request_n,
  input  wire logic [1:0]                bus_width_sel,
  input  wire logic [pcl_pkg::DATA_W-1:0] config_data,
  // Configuration status line, open drain
  input  wire logic                      config_status_n_i,
  output var  logic                      config_status_n_o,
  output var  logic                      config_status_n_oe,
  // Load-complete line, open drain
  input  wire logic                      load_complete_i,
  output var  logic                      load_complete_o,
  output var  logic                      load_complete_oe,
  // Initialization-complete line, open drain
  input  wire logic                      init_done_i,
  output var  logic                      init_done_o,
  output var  logic                      init_done_oe,
  // Word stream to the configuration memory
  output var  pcl_pkg::pcl_word_t        cfg_word,
  output var  logic                      cfg_word_valid,
  input  wire logic                      cfg_word_ready,
  // Core status
  output var  logic                      user_mode,
  output var  logic                      user_io_release,
  output var  logic                      config_error
);

  import pcl_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  pcl_state_t      state_r;
  pcl_state_t      state_nxt;
  pcl_width_t      width_r;
  logic [POR_CW-1:0] por_cnt_r;
  logic [31:0]     dcnt_r;
  logic            opt_init_r;
  logic            hold_req_r;
  logic            edge_clr_r;
  logic            status_oe_r;
  logic            lc_oe_r;
  logic            init_oe_r;
  logic            user_r;
  logic            err_r;
  pcl_word_t       out_r;
  logic            out_valid_r;
  logic [31:0]     lcnt_r;
  logic            all_l_r;
  logic            ovf_l_r;
  logic [1:0]      fall_cnt_r;
  logic [3:0]      pin_s;
  logic [1:0]      link_s;
  pcl_word_t       link_word;
  pcl_word_t       fifo_word;
  logic [DATA_W-1:0] masked;
  wire             fifo_wr_ready;
  wire             fifo_rd_valid;
  wire             fifo_rd_ready;
  wire             link_push;
  wire             link_last;
  wire             rd_fire;
  wire             req_low;
  wire             por_done;
  wire             load_done;
  wire             ovf_s;
  wire             edges_s;
  wire             edges_l;
  wire             nxt_active;

  //////////////////////////////////////////////////////////////////////////
  // Pin and link-flag synchronisers in the system domain

  // Request pin and width strap, two flops each
  pcl_sync #(.WIDTH(4)) u_pin_sync (
    .clk (clk),
    .clr (1'b0),
    .d   ({reconfig_request_n, config_status_n_i, bus_width_sel}),
    .q   (pin_s)
  );

  // Overflow and init-edge flags from the link domain
  pcl_sync #(.WIDTH(2)) u_link_sync (
    .clk (clk),
    .clr (hold_req_r),
    .d   ({ovf_l_r, edges_l}),
    .q   (link_s)
  );

  assign req_low = ~pin_s[3];
  assign ovf_s   = link_s[1];
  assign edges_s = link_s[0];

  //////////////////////////////////////////////////////////////////////////
  // Link domain: capture on the configuration clock
  //
  // The link logic is cleared asynchronously by hold_req_r, a flop of the
  // system domain. The clear lifts in the cycle that releases the status
  // line, well before the host starts clocking, so the first word is kept.
  // The width strap is frozen on that same clock edge and is read directly.

  // Narrow modes take the low data lines, upper bits forced to zero
  assign masked =
    (width_r == PCL_W8)  ? {24'h00_0000, config_data[7:0]} :
    (width_r == PCL_W16) ? {16'h0000, config_data[15:0]}  :
                           config_data;

  // One word per clock until the last one, then the clock is ignored
  assign link_push = ~all_l_r;
  assign link_last = lcnt_r == 32'(BITSTREAM_WORDS - 1);
  assign link_word = '{last: link_last, data: masked};

  // Word counter and overflow flag, rising edge
  always_ff @(posedge config_clock or posedge hold_req_r) begin
    if (hold_req_r) begin
      lcnt_r  <= '0;
      all_l_r <= 1'b0;
      ovf_l_r <= 1'b0;
    end else if (link_push) begin
      lcnt_r  <= lcnt_r + 32'h0000_0001;
      all_l_r <= link_last;
      ovf_l_r <= ovf_l_r | ~fifo_wr_ready;
    end
  end

  // Falling edges after load-complete rises; cleared while it is low
  always_ff @(negedge config_clock or posedge edge_clr_r) begin
    if (edge_clr_r) begin
      fall_cnt_r <= '0;
    end else if (fall_cnt_r != 2'(INIT_EDGES)) begin
      fall_cnt_r <= fall_cnt_r + 2'h1;
    end
  end

  assign edges_l = fall_cnt_r == 2'(INIT_EDGES);

  //////////////////////////////////////////////////////////////////////////
  // Word buffer between the two domains

  // A full buffer cannot stall the host, so a lost word is an error
  pcl_fifo #(
    .WIDTH ($bits(pcl_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .wr_clk   (config_clock),
    .wr_clr   (hold_req_r),
    .wr_valid (link_push),
    .wr_ready (fifo_wr_ready),
    .wr_data  (link_word),
    .rd_clk   (clk),
    .rd_clr   (hold_req_r),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_word)
  );

  // Output stage stalls the buffer when the core is not ready
  assign fifo_rd_ready = ~out_valid_r | cfg_word_ready;
  assign rd_fire       = fifo_rd_valid & fifo_rd_ready;

  always_ff @(posedge clk) begin
    if (sys_rst || hold_req_r) begin
      out_r       <= '{last: 1'b0, data: WORD_RST};
      out_valid_r <= 1'b0;
    end else if (fifo_rd_ready) begin
      out_r       <= fifo_word;
      out_valid_r <= fifo_rd_valid;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer

  assign por_done  = por_cnt_r == POR_CW'(POR_CYCLES - 1);
  assign load_done = dcnt_r == 32'(BITSTREAM_WORDS);

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PCL_POR: begin
        if (por_done) begin
          state_nxt = req_low ? PCL_HOLD : PCL_CFG;
        end
      end
      PCL_HOLD: begin
        if (!req_low) begin
          state_nxt = PCL_CFG;
        end
      end
      PCL_CFG: begin
        if (req_low) begin
          state_nxt = PCL_HOLD;
        end else if (ovf_s) begin
          state_nxt = PCL_ERR;
        end else if (load_done) begin
          state_nxt = PCL_LOADED;
        end
      end
      PCL_LOADED: begin
        if (req_low) begin
          state_nxt = PCL_HOLD;
        end else if (edges_s) begin
          state_nxt = PCL_USER;
        end
      end
      PCL_USER: begin
        if (req_low) begin
          state_nxt = PCL_HOLD;
        end
      end
      PCL_ERR: begin
        if (req_low) begin
          state_nxt = PCL_HOLD;
        end
      end
      default: begin
        state_nxt = PCL_POR;
      end
    endcase
  end

  assign nxt_active = (state_nxt == PCL_CFG) || (state_nxt == PCL_LOADED);

  // State and power-on counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r   <= PCL_POR;
      por_cnt_r <= '0;
    end else begin
      state_r   <= state_nxt;
      por_cnt_r <= por_done ? por_cnt_r : por_cnt_r + POR_CW'(1);
    end
  end

  // Width strap is followed during power-on and frozen after it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      width_r <= PCL_W32;
    end else if (state_r == PCL_POR) begin
      width_r <= pcl_width_t'(pin_s[1:0]);
    end
  end

  // Drained word count and init-done option from the first word
  always_ff @(posedge clk) begin
    if (sys_rst || hold_req_r) begin
      dcnt_r <= '0;
    end else if (rd_fire) begin
      dcnt_r <= dcnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || state_r == PCL_HOLD) begin
      opt_init_r <= 1'b0;
    end else if (rd_fire && dcnt_r == '0) begin
      opt_init_r <= fifo_word.data[OPT_INIT_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered pin controls, decoded from the next state

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_oe_r <= 1'b1;
      lc_oe_r     <= 1'b1;
      init_oe_r   <= 1'b0;
      user_r      <= 1'b0;
      err_r       <= 1'b0;
      hold_req_r  <= 1'b1;
      edge_clr_r  <= 1'b1;
    end else begin
      // Status low in power-on, hold and error; released in user mode
      status_oe_r <= (state_nxt == PCL_POR) || (state_nxt == PCL_HOLD) ||
                     (state_nxt == PCL_ERR);
      // Done stays low until every word has left the buffer
      lc_oe_r     <= (state_nxt != PCL_LOADED) &&
                     (state_nxt != PCL_USER);
      init_oe_r   <= opt_init_r && nxt_active;
      user_r      <= state_nxt == PCL_USER;
      err_r       <= state_nxt == PCL_ERR;
      // Link logic cleared outside a load, so the clock is ignored
      hold_req_r  <= ~nxt_active;
      edge_clr_r  <= state_nxt != PCL_LOADED;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open-drain lines only ever pull low
  assign config_status_n_o  = 1'b0;
  assign config_status_n_oe = status_oe_r;
  assign load_complete_o    = 1'b0;
  assign load_complete_oe   = lc_oe_r;
  assign init_done_o        = 1'b0;
  assign init_done_oe       = init_oe_r;
  assign cfg_word           = out_r;
  assign cfg_word_valid     = out_valid_r;
  assign user_mode          = user_r;
  assign user_io_release    = user_r;
  assign config_error       = err_r;

endmodule : pcl_loader
`default_nettype wire

/* verif/pcl_loader_chk.sv */
// Checker: port assertions for the parallel configuration loader
`timescale 1ns/1ps
`default_nettype none
module pcl_loader_chk
  import pcl_pkg::*;
#(
  parameter int unsigned BITSTREAM_WORDS = pcl_pkg::WORDS_DFLT
) (
  // Clock, reset and host pins
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               reconfig_request_n,
  input wire logic [1:0]         bus_width_sel,
  // Line enables and core side
  input wire logic               config_status_n_oe,
  input wire logic               load_complete_oe,
  input wire logic               init_done_oe,
  input wire pcl_pkg::pcl_word_t cfg_word,
  input wire logic               cfg_word_valid,
  input wire logic               cfg_word_ready,
  input wire logic               user_mode,
  input wire logic               user_io_release,
  input wire logic               config_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // Cycles since reset (saturating) and words taken since restart
  logic [12:0] por_cnt_r;
  logic [12:0] por_cnt_nxt;
  logic [15:0] wcnt_r;
  logic [15:0] wcnt_nxt;
  assign por_cnt_nxt = (&por_cnt_r) ? por_cnt_r : por_cnt_r + 13'h0001;
  assign wcnt_nxt = (cfg_word_valid && cfg_word_ready) ? wcnt_r + 16'h0001
                                                        : wcnt_r;
  always_ff @(posedge clk) begin
    por_cnt_r <= sys_rst ? 13'h0000 : por_cnt_nxt;
    wcnt_r    <= (sys_rst || !reconfig_request_n) ? 16'h0000 : wcnt_nxt;
  end
  // Request patterns; the pin is synchronised, hence the settle cycles
  sequence s_req_low_user;
    user_mode && !reconfig_request_n ##1 !reconfig_request_n;
  endsequence
  sequence s_err_req_high;
    reconfig_request_n [*3] ##1 (config_error && reconfig_request_n);
  endsequence
  chk_reconfig_restart: assert property (
    s_req_low_user |-> ##[0:4] (!user_mode && config_status_n_oe))
    else $error("request low in user mode did not restart");
  chk_user_lines_high: assert property (
    user_mode |-> !config_status_n_oe && !load_complete_oe)
    else $error("line pulled low in user mode");
  chk_por_status_low: assert property (
    por_cnt_r < 13'(POR_CYCLES - 10) |-> config_status_n_oe)
    else $error("status released inside power-on delay");
  chk_reset_lines_low: assert property (
    $past(sys_rst) |-> load_complete_oe && config_status_n_oe)
    else $error("lines not held low after reset");
  chk_done_all_words: assert property (
    $fell(load_complete_oe) |-> (!cfg_word_valid || cfg_word.last) &&
    (wcnt_r + 16'(cfg_word_valid)) == 16'(BITSTREAM_WORDS))
    else $error("load complete before every word arrived");
  chk_narrow_bits: assert property (
    cfg_word_valid |->
    (bus_width_sel != PCL_W8 || cfg_word.data[31:8] == 24'h00_0000) &&
    (bus_width_sel != PCL_W16 || cfg_word.data[31:16] == 16'h0000))
    else $error("upper data bits set in narrow mode");
  chk_io_with_user: assert property (
    user_io_release == user_mode)
    else $error("pin release differs from user mode");
  chk_user_no_words: assert property (
    user_mode |-> !cfg_word_valid)
    else $error("word produced in user mode");
  chk_init_until_user: assert property (
    init_done_oe |-> !user_mode)
    else $error("init line low in user mode");
  // Error and user mode flush the output stage, so a stalled word may go
  chk_word_held: assert property (
    reconfig_request_n [*4] ##0 (cfg_word_valid && !cfg_word_ready &&
    !config_error && !user_mode)
    |=> cfg_word_valid && $stable(cfg_word))
    else $error("stalled word changed or dropped");
  chk_error_lines: assert property (
    config_error |-> config_status_n_oe && load_complete_oe && !user_mode)
    else $error("error state without lines low");
  chk_error_sticky: assert property (
    s_err_req_high |=> config_error)
    else $error("error cleared without request");
endmodule : pcl_loader_chk
`default_nettype wire

/* verif/pcl_host_model.sv */
// Host model: drives configuration clock, data and request pins
`timescale 1ns/1ps
`default_nettype none
module pcl_host_model (
  // Host-driven pins
  output var logic        config_clock,
  output var logic [31:0] config_data,
  output var logic        reconfig_request_n
);
  localparam int HALF = 16; // Half of the 32 ns link period
  ////////////////////////////////////////////////////////////
  // Pins are driven from time zero and never left floating
  initial begin
    config_clock       = 1'h0;
    config_data        = 32'h0000_0000;
    reconfig_request_n = 1'h1;
  end
  // One word per clock; data moves only while the clock is low
  task automatic send(input int first, input int cnt, input logic [31:0] base);
    for (int i = first; i < first + cnt; i++) begin
      config_data = base + 32'(i);
      #HALF config_clock = 1'h1;
      #HALF config_clock = 1'h0;
    end
    // Scrambled idle data so a stale word cannot pass for a new one
    #HALF config_data = ~config_data;
  endtask : send
  // Two trailing falling edges start initialization
  task automatic falls();
    repeat (2) begin
      #HALF config_clock = 1'h1;
      #HALF config_clock = 1'h0;
    end
  endtask : falls
  // Request level; low asks for a fresh configuration
  task automatic req(input logic lvl);
    reconfig_request_n = lvl;
  endtask : req
endmodule : pcl_host_model
`default_nettype wire

/* verif/tb_pcl_loader.sv */
// Testbench: host model, core sink and scenarios for the loader
`timescale 1ns/1ps
`default_nettype none
module tb_pcl_loader;
  import pcl_pkg::*;
  localparam int NW = 24;
  ////////////////////////////////////////////////////////////
  // Pins, pulled-up open-drain lines and bench state
  logic             clk;
  logic             sys_rst;
  logic             cfg_word_ready;
  logic [1:0]       bus_width_sel;
  wire logic        config_clock;
  wire logic        reconfig_request_n;
  wire logic [31:0] config_data;
  logic             st_o, st_oe, lc_o, lc_oe, id_o, id_oe;
  logic             cfg_word_valid, user_mode, user_io_release, config_error;
  pcl_word_t        cfg_word;
  wire logic        st_ln = st_oe ? st_o : 1'h1;
  wire logic        lc_ln = lc_oe ? lc_o : 1'h1;
  wire logic        id_ln = id_oe ? id_o : 1'h1;
  wire logic [3:0]  mon = {config_error, user_mode, lc_ln, st_ln};
  int               errors;
  int               cmp_count;
  pcl_word_t        got_q[$];
  initial clk = 1'h0;
  always #12.5 clk = ~clk;
  pcl_loader #(.BITSTREAM_WORDS(NW)) dut (
    .clk, .sys_rst, .config_clock, .reconfig_request_n, .bus_width_sel,
    .config_data, .config_status_n_i(st_ln), .config_status_n_o(st_o),
    .config_status_n_oe(st_oe), .load_complete_i(lc_ln),
    .load_complete_o(lc_o), .load_complete_oe(lc_oe), .init_done_i(id_ln),
    .init_done_o(id_o), .init_done_oe(id_oe), .cfg_word, .cfg_word_valid,
    .cfg_word_ready, .user_mode, .user_io_release, .config_error
  );
  pcl_host_model host (.config_clock, .config_data, .reconfig_request_n);
  // Core sink: pre-edge values are read, so no race with the design
  always @(posedge clk) begin
    if (!sys_rst && cfg_word_valid && cfg_word_ready) begin
      got_q.push_back(cfg_word);
    end
  end
  task automatic chk(input string what, input logic [32:0] seen,
                     input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  // Bounded wait on one monitored line; running out ends the run
  task automatic wait_ln(input int b, input logic lvl, input int lim);
    int n;
    n = 0;
    while (mon[b] !== lvl) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        chk("wait", mon[b], lvl);
        close_out();
      end
    end
  endtask : wait_ln
  // Width strap is only followed during power-on, so set it in reset
  task automatic do_reset(input logic [1:0] w);
    @(negedge clk);
    sys_rst = 1'h1;
    bus_width_sel = w;
    repeat (5) @(negedge clk);
    sys_rst = 1'h0;
  endtask : do_reset
  task automatic por_check();
    repeat (POR_CYCLES - 10) @(negedge clk);
    chk("status_por", st_ln, 0);
    chk("done_por", lc_ln, 0);
    wait_ln(0, 1'h1, 40);
  endtask : por_check
  // Full load: last word held back, then init edges and user mode
  task automatic load(input logic [31:0] base, input logic [31:0] mask);
    got_q.delete();
    host.send(0, NW - 1, base);
    repeat (20) @(negedge clk);
    chk("done_early", lc_ln, 0);
    chk("init_line", id_ln, !base[0]);
    host.send(NW - 1, 1, base);
    wait_ln(1, 1'h1, 40);
    repeat (5) @(negedge clk);
    chk("user_early", user_mode, 0);
    chk("word_count", got_q.size(), NW);
    foreach (got_q[i])
      chk("word", got_q[i], {i == NW - 1, (base + 32'(i)) & mask});
    host.falls();
    wait_ln(2, 1'h1, 20);
    chk("io_release", user_io_release, 1);
    chk("status_user", st_ln, 1);
    chk("init_user", id_ln, 1);
    host.send(0, 4, ~base);
    repeat (10) @(negedge clk);
    chk("words_after", got_q.size(), NW);
    chk("done_user", lc_ln, 1);
  endtask : load
  task automatic reconfig();
    host.req(1'h0);
    wait_ln(2, 1'h0, 10);
    wait_ln(0, 1'h0, 10);
    repeat (10) @(negedge clk);
    host.req(1'h1);
    wait_ln(0, 1'h1, 10);
  endtask : reconfig
  // Core stalls while the host streams on: the buffer must overflow
  task automatic overflow();
    @(negedge clk);
    cfg_word_ready = 1'h0;
    host.send(0, NW, 32'h5A5A_0F0F);
    wait_ln(3, 1'h1, 20);
    repeat (50) @(negedge clk);
    chk("err_status", st_ln, 0);
    chk("err_done", lc_ln, 0);
    cfg_word_ready = 1'h1;
    reconfig();
    chk("err_cleared", config_error, 0);
  endtask : overflow
  initial begin
    sys_rst = 1'h1;
    cfg_word_ready = 1'h1;
    bus_width_sel = 2'h1;
    errors = 0;
    cmp_count = 0;
    do_reset(2'h1);
    por_check();
    load(32'hC3A5_5A01, 32'h0000_FFFF);
    reconfig();
    overflow();
    load(32'h3C5A_A5F0, 32'h0000_FFFF);
    do_reset(2'h0);
    wait_ln(0, 1'h1, POR_CYCLES + 40);
    load(32'hC3A5_5A01, 32'h0000_00FF);
    do_reset(2'h3);
    wait_ln(0, 1'h1, POR_CYCLES + 40);
    load(32'h3C5A_A5F0, 32'hFFFF_FFFF);
    close_out();
  end
endmodule : tb_pcl_loader
bind pcl_loader pcl_loader_chk #(.BITSTREAM_WORDS(BITSTREAM_WORDS)) u_chk (
  .clk, .sys_rst, .reconfig_request_n, .bus_width_sel, .config_status_n_oe,
  .load_complete_oe, .init_done_oe, .cfg_word, .cfg_word_valid,
  .cfg_word_ready, .user_mode, .user_io_release, .config_error
);
`default_nettype wire
